//--- sdb2_map.svh
// Constant map for the burst-of-two DDR SRAM core
`ifndef SDB2_MAP_SVH
`define SDB2_MAP_SVH
`define SDB2_ADDR_W 8
`define SDB2_DEPTH 256
`define SDB2_LANE_W 9
`define SDB2_LANES 4
`define SDB2_BEAT_W 36
`define SDB2_WORD_W 72
`define SDB2_WLANES 8
`define SDB2_X18_LANES 2
`define SDB2_PIPE_LEN 5
`define SDB2_RD_HOLD_STAGE 1
`define SDB2_WR_BEAT1_STAGE 2
`define SDB2_WR_BEAT2_STAGE 3
`define SDB2_RD_BEAT1_STAGE 3
`define SDB2_RD_BEAT2_STAGE 4
`define SDB2_TERM_OFF_FIRST 2
`define SDB2_TERM_OFF_LAST 5
`endif

//--- sdb2_pkg.sv
// Types shared by the burst-of-two DDR SRAM core
package sdb2_pkg;
	// Command kind held in each pipeline slot
	typedef enum logic [1:0] {
		SDB2_NONE = 2'h0,
		SDB2_WRITE = 2'h1,
		SDB2_READ = 2'h3,
		SDB2_DESEL = 2'h2
	} sdb2_cmd_e;
endpackage

//--- sdb2_mem.sv
// Storage array with per-lane write enables and registered read data
`timescale 1ns/1ps
`include "sdb2_map.svh"
module sdb2_mem (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_b,
	// Read side
	input wire logic rd_en,
	input wire logic [`SDB2_ADDR_W-1:0] rd_addr,
	output logic [`SDB2_WORD_W-1:0] rd_data,
	// Write side
	input wire logic wr_en,
	input wire logic [`SDB2_ADDR_W-1:0] wr_addr,
	input wire logic [`SDB2_WORD_W-1:0] wr_data,
	input wire logic [`SDB2_WLANES-1:0] wr_lane_en
);
	logic [`SDB2_WORD_W-1:0] mem_array [`SDB2_DEPTH];
	logic [`SDB2_WORD_W-1:0] rd_data_reg;
	logic [`SDB2_WORD_W-1:0] rd_data_next;

	// ----------------------------------------
	// Read register
	// ----------------------------------------
	always_comb begin
		rd_data_next = rd_data_reg;
		if (rd_en) begin
			rd_data_next = mem_array[rd_addr];
		end
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			rd_data_reg <= '0;
		end else begin
			rd_data_reg <= rd_data_next;
		end
	end

	assign rd_data = rd_data_reg;

	// ----------------------------------------
	// Lane writes
	// ----------------------------------------
	// One process owns the array so no word has two writers
	always_ff @(posedge core_clk) begin
		for (int g = 0; g < `SDB2_WLANES; g++) begin
			if (wr_en && wr_lane_en[g]) begin
				mem_array[wr_addr][g*`SDB2_LANE_W +: `SDB2_LANE_W] <=
					wr_data[g*`SDB2_LANE_W +: `SDB2_LANE_W];
			end
		end
	end
endmodule

//--- sdb2_core.sv
// Command decode and beat sequencing of a burst-of-two DDR SRAM
//
// What this block does
// - Load-select high accepts no command; deselect follows once bursts finish.
// - Load-select low with read/write high is read; with it low, write.
// - Read at edge n drives both data beats starting at edge n+3.
// - Write at edge n takes first data beat at edge n+2.
// - Second write beat comes on next complementary edge; two beats per address.
// - Termination off: data pins float one cycle, 1.5 cycles after NOP/write.
// - Termination on: drivers still off that cycle; termination sets level.
// - Lanes enabled in both beats store bytes of both beats.
// - Lanes enabled only in first beat store first beat only.
// - Lanes enabled only in second beat store second beat only.
// - All masks high in both beats aborts; memory stays unchanged.
// - A high active-low mask blocks its lane, keeping the stored byte.
// - 18-bit mode: two masks gate bits 0-8 and 9-17, any combination.
// - 36-bit mode: four masks gate four 9-bit lanes, all combinations.
`timescale 1ns/1ps
`include "sdb2_map.svh"
module sdb2_core (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_b,
	// Command and address
	input wire logic command_select_n,
	input wire logic read_write_sel,
	input wire logic [`SDB2_ADDR_W-1:0] addr,
	// Configuration
	input wire logic width_x36,
	input wire logic input_termination_enable,
	// Write data and masks
	input wire logic [`SDB2_BEAT_W-1:0] dq_in,
	input wire logic [`SDB2_LANES-1:0] byte_lane_mask_n,
	// Read data and pin control
	output logic [`SDB2_BEAT_W-1:0] dq_out,
	output logic dq_oe,
	output logic dq_term_on,
	output logic k_phase
);
	// ----------------------------------------
	// Lane enable decode
	// ----------------------------------------
	function automatic logic [`SDB2_LANES-1:0] lane_enables(
		input logic [`SDB2_LANES-1:0] mask_n,
		input logic x36
	);
		logic [`SDB2_LANES-1:0] en;
		en = ~mask_n;
		if (!x36) begin
			en[`SDB2_LANES-1:`SDB2_X18_LANES] = '0;
		end
		return en;
	endfunction

	// ----------------------------------------
	// State
	// ----------------------------------------
	logic phase_reg;
	logic phase_next;
	sdb2_pkg::sdb2_cmd_e cmd_p_reg [1:`SDB2_PIPE_LEN];
	sdb2_pkg::sdb2_cmd_e cmd_p_next [1:`SDB2_PIPE_LEN];
	logic [`SDB2_ADDR_W-1:0] addr_p_reg [1:`SDB2_WR_BEAT2_STAGE];
	logic [`SDB2_ADDR_W-1:0] addr_p_next [1:`SDB2_WR_BEAT2_STAGE];
	logic [`SDB2_BEAT_W-1:0] wbeat_reg;
	logic [`SDB2_BEAT_W-1:0] wbeat_next;
	logic [`SDB2_LANES-1:0] wmask_reg;
	logic [`SDB2_LANES-1:0] wmask_next;
	logic [`SDB2_WORD_W-1:0] rd_hold_reg;
	logic [`SDB2_WORD_W-1:0] rd_hold_next;
	logic [`SDB2_BEAT_W-1:0] rbeat2_reg;
	logic [`SDB2_BEAT_W-1:0] rbeat2_next;
	logic [`SDB2_BEAT_W-1:0] dq_out_reg;
	logic [`SDB2_BEAT_W-1:0] dq_out_next;
	logic dq_oe_reg;
	logic dq_oe_next;
	logic dq_term_on_reg;
	logic dq_term_on_next;
	logic term_s1_reg;
	logic term_s2_reg;
	sdb2_pkg::sdb2_cmd_e cmd_cur;
	logic mem_rd_en;
	logic [`SDB2_WORD_W-1:0] mem_rd_data;
	logic mem_wr_en;
	logic [`SDB2_WORD_W-1:0] mem_wr_data;
	logic [`SDB2_WLANES-1:0] mem_wr_lane_en;
	logic term_off;

	// ----------------------------------------
	// Command decode on the primary edge
	// ----------------------------------------
	always_comb begin
		cmd_cur = sdb2_pkg::SDB2_NONE;
		if (!phase_reg) begin
			if (command_select_n) begin
				cmd_cur = sdb2_pkg::SDB2_DESEL;
			end else if (read_write_sel) begin
				cmd_cur = sdb2_pkg::SDB2_READ;
			end else begin
				cmd_cur = sdb2_pkg::SDB2_WRITE;
			end
		end
	end

	assign mem_rd_en = (cmd_cur == sdb2_pkg::SDB2_READ);

	// ----------------------------------------
	// Write commit after the second beat
	// ----------------------------------------
	always_comb begin
		mem_wr_data = {dq_in, wbeat_reg};
		mem_wr_lane_en = {lane_enables(byte_lane_mask_n, width_x36),
			lane_enables(wmask_reg, width_x36)};
		mem_wr_en = (cmd_p_reg[`SDB2_WR_BEAT2_STAGE] == sdb2_pkg::SDB2_WRITE)
			&& (|mem_wr_lane_en);
	end

	// ----------------------------------------
	// Termination window around read bursts
	// ----------------------------------------
	always_comb begin
		term_off = 1'b0;
		for (int k = `SDB2_TERM_OFF_FIRST; k <= `SDB2_TERM_OFF_LAST; k++) begin
			if (cmd_p_reg[k] == sdb2_pkg::SDB2_READ) begin
				term_off = 1'b1;
			end
		end
	end

	// ----------------------------------------
	// Next values
	// ----------------------------------------
	always_comb begin
		phase_next = ~phase_reg;
		cmd_p_next[1] = cmd_cur;
		for (int k = 2; k <= `SDB2_PIPE_LEN; k++) begin
			cmd_p_next[k] = cmd_p_reg[k-1];
		end
		addr_p_next[1] = addr;
		for (int k = 2; k <= `SDB2_WR_BEAT2_STAGE; k++) begin
			addr_p_next[k] = addr_p_reg[k-1];
		end
		wbeat_next = wbeat_reg;
		wmask_next = wmask_reg;
		if (cmd_p_reg[`SDB2_WR_BEAT1_STAGE] == sdb2_pkg::SDB2_WRITE) begin
			wbeat_next = dq_in;
			wmask_next = byte_lane_mask_n;
		end
		rd_hold_next = rd_hold_reg;
		if (cmd_p_reg[`SDB2_RD_HOLD_STAGE] == sdb2_pkg::SDB2_READ) begin
			rd_hold_next = mem_rd_data;
		end
		rbeat2_next = rbeat2_reg;
		dq_out_next = dq_out_reg;
		dq_oe_next = 1'b0;
		if (cmd_p_reg[`SDB2_RD_BEAT1_STAGE] == sdb2_pkg::SDB2_READ) begin
			dq_out_next = rd_hold_reg[`SDB2_BEAT_W-1:0];
			rbeat2_next = rd_hold_reg[`SDB2_WORD_W-1:`SDB2_BEAT_W];
			dq_oe_next = 1'b1;
		end else if (cmd_p_reg[`SDB2_RD_BEAT2_STAGE] == sdb2_pkg::SDB2_READ) begin
			dq_out_next = rbeat2_reg;
			dq_oe_next = 1'b1;
		end
		dq_term_on_next = term_s2_reg && !term_off;
	end

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			phase_reg <= 1'b0;
			for (int k = 1; k <= `SDB2_PIPE_LEN; k++) begin
				cmd_p_reg[k] <= sdb2_pkg::SDB2_NONE;
			end
			for (int k = 1; k <= `SDB2_WR_BEAT2_STAGE; k++) begin
				addr_p_reg[k] <= '0;
			end
			wbeat_reg <= '0;
			wmask_reg <= '1;
			rd_hold_reg <= '0;
			rbeat2_reg <= '0;
			dq_out_reg <= '0;
			dq_oe_reg <= 1'b0;
			dq_term_on_reg <= 1'b0;
			term_s1_reg <= 1'b0;
			term_s2_reg <= 1'b0;
		end else begin
			phase_reg <= phase_next;
			cmd_p_reg <= cmd_p_next;
			addr_p_reg <= addr_p_next;
			wbeat_reg <= wbeat_next;
			wmask_reg <= wmask_next;
			rd_hold_reg <= rd_hold_next;
			rbeat2_reg <= rbeat2_next;
			dq_out_reg <= dq_out_next;
			dq_oe_reg <= dq_oe_next;
			dq_term_on_reg <= dq_term_on_next;
			term_s1_reg <= input_termination_enable;
			term_s2_reg <= term_s1_reg;
		end
	end

	// ----------------------------------------
	// Storage
	// ----------------------------------------
	sdb2_mem u_mem (
		.core_clk(core_clk),
		.rst_b(rst_b),
		.rd_en(mem_rd_en),
		.rd_addr(addr),
		.rd_data(mem_rd_data),
		.wr_en(mem_wr_en),
		.wr_addr(addr_p_reg[`SDB2_WR_BEAT2_STAGE]),
		.wr_data(mem_wr_data),
		.wr_lane_en(mem_wr_lane_en)
	);

	assign dq_out = dq_out_reg;
	assign dq_oe = dq_oe_reg;
	assign dq_term_on = dq_term_on_reg;
	assign k_phase = phase_reg;
endmodule

//--- sdb2_core_sva.sv
// Assertion checker for the burst-of-two DDR SRAM core
`timescale 1ns/1ps
module sdb2_core_sva (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_b,
	// Command inputs
	input wire logic command_select_n,
	input wire logic read_write_sel,
	input wire logic input_termination_enable,
	// Pin control outputs
	input wire logic dq_oe,
	input wire logic dq_term_on,
	input wire logic k_phase
);
	logic rd;
	logic wr;
	logic nop;
	assign rd = !k_phase && !command_select_n && read_write_sel;
	assign wr = !k_phase && !command_select_n && !read_write_sel;
	assign nop = !k_phase && command_select_n;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_b);
	chk_read_drive: assert property (rd |-> ##4 dq_oe [*2])
		else $error("read burst not driven");
	chk_write_float: assert property (wr |-> ##4 !dq_oe [*2])
		else $error("driver on after write");
	chk_nop_float: assert property (nop |-> ##4 !dq_oe ##1 !dq_oe)
		else $error("driver on after deselect");
	chk_oe_cause: assert property ($rose(dq_oe) |-> $past(rd, 4))
		else $error("driver rose without read");
	chk_oe_end: assert property ($fell(dq_oe) |-> $past(rd, 6))
		else $error("drive length wrong");
	chk_phase_alt: assert property (!k_phase |=> k_phase)
		else $error("phase stuck low");
	chk_term_drive: assert property (dq_oe |-> !dq_term_on)
		else $error("termination on while driving");
	chk_term_cause: assert property ($rose(dq_term_on) |-> $past(input_termination_enable, 3))
		else $error("termination without enable");
	cover property (rd ##2 rd);
	cover property (wr ##2 wr);
	cover property (dq_term_on ##1 !dq_term_on);
endmodule

//--- sdb2_ctl_model.sv
// Controller model driving commands, write beats and lane masks
`timescale 1ns/1ps
module sdb2_ctl_model (
	// Clock and phase
	input wire logic core_clk,
	input wire logic k_phase,
	// Bench requests
	input wire logic req,
	input wire logic req_rd,
	input wire logic [7:0] req_addr,
	input wire logic [71:0] req_d,
	input wire logic [7:0] req_m,
	// Core pins
	output logic command_select_n,
	output logic read_write_sel,
	output logic [7:0] addr,
	output logic [35:0] dq_in,
	output logic [3:0] byte_lane_mask_n
);
	logic pend;
	logic beat2;
	logic [71:0] pd;
	logic [7:0] pm;
	logic [35:0] hd;
	logic [3:0] hm;
	initial {command_select_n, read_write_sel, addr, byte_lane_mask_n, dq_in, pend, beat2} =
		{2'h2, 8'h00, 4'hF, 38'h0};
	always @(posedge core_clk) begin
		if (k_phase) begin
			command_select_n <= !req;
			read_write_sel <= req_rd;
			addr <= req_addr;
			pend <= req && !req_rd;
			pd <= req_d;
			pm <= req_m;
			beat2 <= pend;
			hd <= pd[71:36];
			hm <= pm[7:4];
			dq_in <= pend ? pd[35:0] : ~dq_in;
			byte_lane_mask_n <= pend ? pm[3:0] : 4'hF;
		end else begin
			dq_in <= beat2 ? hd : ~dq_in;
			byte_lane_mask_n <= beat2 ? hm : 4'hF;
		end
	end
endmodule

//--- sdb2_core_tb.sv
// Self-checking bench for the burst-of-two DDR SRAM core
`timescale 1ns/1ps
`define CMP(g, e) begin checks_done++; if ((g) !== (e)) begin errors++; \
$display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end
module sdb2_core_tb;
	logic core_clk = 1'b0;
	logic rst_b = 1'b0;
	logic width_x36 = 1'b1;
	logic input_termination_enable = 1'b0;
	logic req = 1'b0;
	logic req_rd = 1'b0;
	logic [7:0] req_addr = 8'h00;
	logic [71:0] req_d = 72'h0;
	logic [7:0] req_m = 8'hFF;
	logic command_select_n;
	logic read_write_sel;
	logic [7:0] addr;
	logic [35:0] dq_in;
	logic [3:0] byte_lane_mask_n;
	logic [35:0] dq_out;
	logic dq_oe;
	logic dq_term_on;
	logic k_phase;
	logic [71:0] shadow [256];
	int errors = 0;
	int checks_done = 0;
	always #2.5 core_clk = ~core_clk;
	sdb2_core dut_u (.core_clk, .rst_b, .command_select_n, .read_write_sel, .addr, .width_x36,
		.input_termination_enable, .dq_in, .byte_lane_mask_n, .dq_out, .dq_oe, .dq_term_on,
		.k_phase);
	sdb2_ctl_model ctl_u (.core_clk, .k_phase, .req, .req_rd, .req_addr, .req_d, .req_m,
		.command_select_n, .read_write_sel, .addr, .dq_in, .byte_lane_mask_n);
	function automatic logic [71:0] merge(logic [71:0] o, logic [71:0] d, logic [7:0] m);
		for (int i = 0; i < 8; i++) if (!m[i] && (width_x36 || i % 4 < 2)) o[i*9 +: 9] = d[i*9 +: 9];
		return o;
	endfunction
	task automatic wrap_up();
		if (errors == 0 && checks_done > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	task automatic cmd(logic rd, logic [7:0] a, logic [71:0] d, logic [7:0] m);
		do @(negedge core_clk); while (k_phase !== 1'b0);
		@(posedge core_clk);
		req <= 1'b1;
		req_rd <= rd;
		req_addr <= a;
		req_d <= d;
		req_m <= m;
		@(posedge core_clk);
		req <= 1'b0;
		if (!rd) shadow[a] = merge(shadow[a], d, m);
	endtask
	task automatic rd_burst(logic [7:0] a, logic [7:0] b);
		logic [71:0] w;
		repeat (2) @(posedge core_clk);
		cmd(1'b1, a, 72'h0, 8'hFF);
		cmd(1'b1, b, 72'h0, 8'hFF);
		repeat (2) @(posedge core_clk);
		for (int i = 0; i < 4; i++) begin
			@(negedge core_clk);
			w = (i < 2 ? shadow[a] : shadow[b]) >> (36 * (i % 2));
			`CMP({dq_oe, dq_term_on}, 2'h2)
			`CMP(dq_out, w[35:0])
		end
		@(negedge core_clk);
		`CMP(dq_oe, 1'b0)
	endtask
	task automatic t_full();
		cmd(1'b0, 8'h10, {8{9'h1A5}}, 8'h00);
		cmd(1'b0, 8'h11, {8{9'h0C3}}, 8'h00);
		rd_burst(8'h10, 8'h11);
	endtask
	task automatic t_masks();
		logic [7:0] a;
		for (int i = 0; i < 17; i++) begin
			a = 8'h20 + i[7:0];
			cmd(1'b0, a, {8{9'h155}}, 8'h00);
			cmd(1'b0, a, {8{a, 1'b1}}, i < 16 ? {~i[3:0], i[3:0]} : 8'hFF);
			rd_burst(a, a);
		end
	endtask
	task automatic t_x18();
		cmd(1'b0, 8'h40, {8{9'h1FF}}, 8'h00);
		repeat (4) @(posedge core_clk);
		width_x36 <= 1'b0;
		for (int i = 0; i < 4; i++) begin
			cmd(1'b0, 8'h40, {8{9'h0A0 ^ i[8:0]}}, {2'h0, ~i[1:0], 2'h0, i[1:0]});
			rd_burst(8'h40, 8'h40);
		end
		@(posedge core_clk);
		width_x36 <= 1'b1;
	endtask
	task automatic t_term();
		@(posedge core_clk);
		input_termination_enable <= 1'b1;
		repeat (6) @(negedge core_clk);
		`CMP(dq_term_on, 1'b1)
		cmd(1'b0, 8'h11, {8{9'h033}}, 8'hF0);
		rd_burst(8'h11, 8'h10);
		repeat (4) @(negedge core_clk);
		`CMP(dq_term_on, 1'b1)
	endtask
	initial begin
		@(negedge core_clk);
		`CMP({dq_oe, dq_term_on, dq_out}, 38'h0)
		@(posedge core_clk);
		rst_b <= 1'b1;
		t_full();
		t_masks();
		t_x18();
		t_term();
		wrap_up();
	end
	initial begin
		#50us;
		errors++;
		wrap_up();
	end
endmodule
bind sdb2_core sdb2_core_sva chk_u (.core_clk, .rst_b, .command_select_n, .read_write_sel,
	.input_termination_enable, .dq_oe, .dq_term_on, .k_phase);
